//--- pms_regs.svh
// Constants of the power supervisor: register indices, field positions,
// reset values and timing counts. Included by the supervisor module.
// Functional notes
// - Each rail faults at 10% below target, clears after 5% recovery.
// - Disabled regulator: comparator ignored, status bit reports good.
// - Any monitored rail below its fault threshold raises the interrupt.
// - Shared pin enables both linear regulators; register can disable or retune.
// - All regulators off during undervoltage lockout or over-temperature.
// - Each buck has its own enable pin, high enables, low disables.
// - Buck1 strap low gives 1.2 V default, high gives 1.6 V.
// - Buck3 strap low gives 1.8 V default, high gives 3.3 V.
// - Warm reset restores buck1 voltage to strap default, nothing else.
// - Warm reset request is debounced for about 30 ms.
// - System reset low while backup rail low, then stretched about 100 ms.
// - System reset is open drain: pulled low or released.
// - Debounced warm reset also forces system reset low.
// - Buck1 reverts on warm reset, backup low, lockout or system reset.
// - Power-fail and low-battery flags from 1 V detectors with hysteresis.
// - Linear regulator straps latched at power-up; software may change after.
// - Strap code picks one of four pairs; 00 gives 1.3 V and 3.3 V.
// - At power-up interrupt low until last enabled rail is in regulation.
// - Enabled rail leaving regulation sets its bit and drives interrupt low.
// - Status read while interrupt low releases it; bit stays while bad.
// - Per-source fault mask; default leaves all rail sources unmasked.
// - With no supply enabled the interrupt is low regardless of mask.
// - Status bits 7..1: power fail, low battery, buck1..3, linreg2, linreg1.
// - Mask bit 1 blocks its source; lockout resets mask to C0h.
// - Effective enable is pin AND control bit; control resets to FFh.
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// Register indices, byte address is four times the index
`define PMS_IDX_STATUS     10'h001
`define PMS_IDX_MASK       10'h002
`define PMS_IDX_SUPPLY_EN  10'h003
`define PMS_IDX_LINREG_V   10'h004
`define PMS_IDX_BUCK1_V    10'h005
`define PMS_IDX_BUCK3_V    10'h006
`define PMS_IDX_STRETCH    10'h007
`define PMS_IDX_DEBOUNCE   10'h008

// Reset values and the value read from unmapped words
`define PMS_MASK_RST       8'hC0
`define PMS_SUPPLY_EN_RST  8'hFF
`define PMS_UNMAPPED_RD    32'h0000_00FF

// Supply enable control bit positions
`define PMS_BIT_BUCK1      5
`define PMS_BIT_BUCK2      4
`define PMS_BIT_BUCK3      3
`define PMS_BIT_LINREG2    2
`define PMS_BIT_LINREG1    1

// Voltage codes in 25 mV steps
`define PMS_V_1V2          8'h30
`define PMS_V_1V3          8'h34
`define PMS_V_1V6          8'h40
`define PMS_V_1V8          8'h48
`define PMS_V_2V1          8'h54
`define PMS_V_2V8          8'h70
`define PMS_V_3V3          8'h84

// Timing: pclk rate, slow tick rate, filter and stretch times
`define PMS_CLK_HZ         20000000
`define PMS_SLOW_HZ        32000
`define PMS_SLOW_DIV       (`PMS_CLK_HZ / `PMS_SLOW_HZ)
`define PMS_DEB_MS         30
`define PMS_DEB_TICKS      ((`PMS_DEB_MS * `PMS_SLOW_HZ) / 1000)
`define PMS_STRETCH_MS     100
`define PMS_STRETCH_TICKS  ((`PMS_STRETCH_MS * `PMS_SLOW_HZ) / 1000)

`endif

//--- pms_pkg.sv
// Types shared by the power supervisor and its bench.
// Assumes the constants header is included alongside.
package pms_pkg;

   // Comparator results, index 0 linreg1 .. 4 buck1, 5 low batt, 6 power fail
   typedef struct packed {
      logic [6:0] trip;
      logic [6:0] recover;
   } pms_cmp_s;

   // Strap pins sampled once after lockout ends
   typedef struct packed {
      logic buck1_default_select;
      logic buck3_default_select;
      logic linreg_default_sel_a;
      logic linreg_default_sel_b;
   } pms_strap_s;

   // Effective supply enables
   typedef struct packed {
      logic buck1;
      logic buck2;
      logic buck3;
      logic linreg2;
      logic linreg1;
   } pms_en_s;

   // System reset sequence
   typedef enum logic [1:0] {
      PMS_RST_HOLD    = 2'b00,
      PMS_RST_STRETCH = 2'b01,
      PMS_RST_RUN     = 2'b10
   } pms_rst_e;

endpackage

//--- pms_supervisor.sv
// Supervisor logic: rail fault status, interrupt, supply enables,
// strap defaults, warm reset filter and stretched system reset.
// Assumes presetn is the undervoltage lockout, all pins synchronous to pclk.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`include "pms_regs.svh"

module pms_supervisor #(
   parameter int SLOW_DIV = `PMS_SLOW_DIV
) (
   // Clock and lockout reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Enable pins and thermal flag
   input  wire logic              buck1_enable,
   input  wire logic              buck2_enable,
   input  wire logic              buck3_enable,
   input  wire logic              linreg_group_enable,
   input  wire logic              over_temp,
   // Straps and analog monitor results
   input  wire pms_pkg::pms_strap_s straps,
   input  wire pms_pkg::pms_cmp_s  cmp,
   input  wire logic              backup_rail_low,
   input  wire logic              warm_reset_request_n,
   // Regulator controls
   output pms_pkg::pms_en_s       supply_on,
   output logic [7:0]             buck1_vsel,
   output logic [7:0]             buck3_vsel,
   output logic [15:0]            linreg_voltage_control,
   // Flags
   output logic                   power_fail_flag,
   output logic                   low_battery_flag,
   // Open-drain pins, drive enable low while pulling low
   output logic                   system_reset_out_o,
   output logic                   system_reset_out_oe_n,
   output logic                   irq_o,
   output logic                   irq_oe_n
);
   import pms_pkg::*;

   // Bus decode
   logic [9:0]  idx;
   logic        wr_acc;
   logic        rd_acc;

   // Registers
   logic [7:0]  mask_r;
   logic [7:0]  supply_en_r;
   logic [7:0]  buck1_v_r;
   logic [7:0]  buck3_v_r;
   logic [15:0] linreg_v_r;
   logic [11:0] stretch_tc_r;
   logic [11:0] deb_tc_r;

   // Strap defaults
   logic        strap_done_r;
   logic        buck1_def;
   logic [7:0]  buck1_dflt_r;
   logic [15:0] linreg_dflt;
   logic [7:0]  buck3_dflt;

   // Enables and faults
   logic [4:0]  pins;
   logic [4:0]  en_r;
   logic [6:0]  active;
   logic [6:0]  fault_r;
   logic [6:0]  fault_d_r;
   logic [7:0]  status;
   logic [7:0]  pending;
   logic        none_on;
   logic        irq_quiet_r;
   logic        irq_low;

   // Timers and reset
   logic [15:0] div_cnt_r;
   logic        tick_r;
   logic        warm_r;
   logic [11:0] deb_cnt_r;
   logic [11:0] str_cnt_r;
   pms_rst_e    rst_st_r;
   logic        rst_out;

   // Read path
   logic [31:0] rd_mux;

   // APB decode, zero wait states
   assign idx     = paddr[11:2];
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // Strap decode of the linear regulator pair
   always_comb begin
      case ({straps.linreg_default_sel_b, straps.linreg_default_sel_a})
         2'b00:   linreg_dflt = {`PMS_V_3V3, `PMS_V_1V3};
         2'b01:   linreg_dflt = {`PMS_V_3V3, `PMS_V_2V8};
         2'b10:   linreg_dflt = {`PMS_V_1V8, `PMS_V_1V3};
         2'b11:   linreg_dflt = {`PMS_V_3V3, `PMS_V_2V1};
         default: linreg_dflt = {`PMS_V_3V3, `PMS_V_1V3};
      endcase
   end

   // Buck strap decode
   assign buck3_dflt = straps.buck3_default_select ? `PMS_V_3V3
                                                   : `PMS_V_1V8;
   assign buck1_def  = straps.buck1_default_select;

   // Straps caught once, first edge after lockout ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_done_r <= 1'b0;
         buck1_dflt_r <= `PMS_V_1V2;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         buck1_dflt_r <= buck1_def ? `PMS_V_1V6 : `PMS_V_1V2;
      end
   end

   // Fault mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= `PMS_MASK_RST;
      end else if (wr_acc && idx == `PMS_IDX_MASK) begin
         mask_r <= pwdata[7:0];
      end
   end

   // Supply enable control, pin low forces its bit back to default
   assign pins = {buck1_enable, buck2_enable, buck3_enable,
                  linreg_group_enable, linreg_group_enable};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_en_r <= `PMS_SUPPLY_EN_RST;
      end else begin
         if (wr_acc && idx == `PMS_IDX_SUPPLY_EN) begin
            supply_en_r <= pwdata[7:0];
         end

         // Pin low wins over a write in the same cycle
         if (!pins[4]) supply_en_r[`PMS_BIT_BUCK1]   <= 1'b1;
         if (!pins[3]) supply_en_r[`PMS_BIT_BUCK2]   <= 1'b1;
         if (!pins[2]) supply_en_r[`PMS_BIT_BUCK3]   <= 1'b1;
         if (!pins[1]) supply_en_r[`PMS_BIT_LINREG2] <= 1'b1;
         if (!pins[0]) supply_en_r[`PMS_BIT_LINREG1] <= 1'b1;
      end
   end

   // Effective enables, held off until straps are settled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= 5'b0_0000;
      end else if (!strap_done_r || over_temp) begin
         en_r <= 5'b0_0000;
      end else begin
         en_r <= pins & supply_en_r[5:1];
      end
   end
   assign supply_on = pms_en_s'(en_r);

   // Linear regulator voltages, strap default then software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         linreg_v_r <= {`PMS_V_3V3, `PMS_V_1V3};
      end else if (!strap_done_r) begin
         linreg_v_r <= linreg_dflt;
      end else if (wr_acc && idx == `PMS_IDX_LINREG_V) begin
         linreg_v_r <= pwdata[15:0];
      end
   end
   assign linreg_voltage_control = linreg_v_r;

   // Buck3 voltage, strap default then software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buck3_v_r <= `PMS_V_1V8;
      end else if (!strap_done_r) begin
         buck3_v_r <= buck3_dflt;
      end else if (wr_acc && idx == `PMS_IDX_BUCK3_V) begin
         buck3_v_r <= pwdata[7:0];
      end
   end
   assign buck3_vsel = buck3_v_r;

   // Buck1 voltage; any reset condition beats a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buck1_v_r <= `PMS_V_1V2;
      end else if (!strap_done_r) begin
         buck1_v_r <= buck1_def ? `PMS_V_1V6 : `PMS_V_1V2;
      end else if (warm_r || backup_rail_low || rst_out) begin
         buck1_v_r <= buck1_dflt_r;
      end else if (wr_acc && idx == `PMS_IDX_BUCK1_V) begin
         buck1_v_r <= pwdata[7:0];
      end
   end
   assign buck1_vsel = buck1_v_r;

   // Timer terminal counts in slow ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stretch_tc_r <= 12'(`PMS_STRETCH_TICKS);
         deb_tc_r     <= 12'(`PMS_DEB_TICKS);
      end else if (wr_acc && idx == `PMS_IDX_STRETCH) begin
         stretch_tc_r <= pwdata[11:0];
      end else if (wr_acc && idx == `PMS_IDX_DEBOUNCE) begin
         deb_tc_r <= pwdata[11:0];
      end
   end

   // Flags always armed, rails only while enabled
   assign active = {2'b11, en_r};

   // Hysteresis fault latch per source: trip sets, recover clears
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_det
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               fault_r[gi] <= 1'b0;
            end else if (!active[gi]) begin
               fault_r[gi] <= 1'b0;
            end else if (cmp.trip[gi]) begin
               fault_r[gi] <= 1'b1;
            end else if (cmp.recover[gi]) begin
               fault_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Status word, bit 0 unused
   assign status           = {fault_r, 1'b0};
   assign power_fail_flag  = fault_r[6];
   assign low_battery_flag = fault_r[5];
   assign pending          = status & ~mask_r;
   assign none_on          = (en_r == 5'b0_0000);

   // Previous faults, to spot a new one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_d_r <= 7'h00;
      end else begin
         fault_d_r <= fault_r;
      end
   end

   // Read-release of the interrupt; a fresh fault re-arms it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_quiet_r <= 1'b0;
      end else if (|((fault_r & ~fault_d_r) & ~mask_r[7:1])) begin
         irq_quiet_r <= 1'b0;
      end else if (rd_acc && idx == `PMS_IDX_STATUS && irq_low) begin
         irq_quiet_r <= 1'b1;
      end else if (pending == 8'h00) begin
         irq_quiet_r <= 1'b0;
      end
   end

   // Interrupt low on unmasked fault or when nothing is on
   assign irq_low  = none_on | ((|pending) & ~irq_quiet_r);
   assign irq_o    = 1'b0;
   assign irq_oe_n = ~irq_low;

   // Slow tick divider standing in for the internal oscillator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r <= 16'h0000;
         tick_r    <= 1'b0;
      end else if (div_cnt_r >= 16'(SLOW_DIV - 1)) begin
         div_cnt_r <= 16'h0000;
         tick_r    <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 16'h0001;
         tick_r    <= 1'b0;
      end
   end

   // Warm reset filter: level must differ for deb_tc ticks to flip
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warm_r    <= 1'b0;
         deb_cnt_r <= 12'h000;
      end else if (warm_r == ~warm_reset_request_n) begin
         deb_cnt_r <= 12'h000;
      end else if (tick_r) begin
         if ({1'b0, deb_cnt_r} + 13'h0001 >= {1'b0, deb_tc_r}) begin
            warm_r    <= ~warm_r;
            deb_cnt_r <= 12'h000;
         end else begin
            deb_cnt_r <= deb_cnt_r + 12'h001;
         end
      end
   end

   // System reset sequence: hold, stretch, run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_st_r  <= PMS_RST_HOLD;
         str_cnt_r <= 12'h000;
      end else begin
         case (rst_st_r)
            PMS_RST_HOLD: begin
               str_cnt_r <= 12'h000;
               if (!backup_rail_low && !warm_r) begin
                  rst_st_r <= PMS_RST_STRETCH;
               end
            end

            PMS_RST_STRETCH: begin
               if (backup_rail_low || warm_r) begin
                  rst_st_r <= PMS_RST_HOLD;
               end else if (tick_r) begin
                  if ({1'b0, str_cnt_r} + 13'h0001 >= {1'b0, stretch_tc_r}) begin
                     rst_st_r <= PMS_RST_RUN;
                  end
                  str_cnt_r <= str_cnt_r + 12'h001;
               end
            end

            PMS_RST_RUN: begin
               if (backup_rail_low || warm_r) begin
                  rst_st_r <= PMS_RST_HOLD;
               end
            end

            default: rst_st_r <= PMS_RST_HOLD;
         endcase
      end
   end

   // Open-drain reset: pulled low unless running
   assign rst_out               = (rst_st_r != PMS_RST_RUN);
   assign system_reset_out_o    = 1'b0;
   assign system_reset_out_oe_n = ~rst_out;

   // Read mux, unmapped words read FFh
   always_comb begin
      rd_mux = `PMS_UNMAPPED_RD;
      case (idx)
         `PMS_IDX_STATUS:    rd_mux = {24'h00_0000, status};
         `PMS_IDX_MASK:      rd_mux = {24'h00_0000, mask_r};
         `PMS_IDX_SUPPLY_EN: rd_mux = {24'h00_0000, supply_en_r};
         `PMS_IDX_LINREG_V:  rd_mux = {16'h0000, linreg_v_r};
         `PMS_IDX_BUCK1_V:   rd_mux = {24'h00_0000, buck1_v_r};
         `PMS_IDX_BUCK3_V:   rd_mux = {24'h00_0000, buck3_v_r};
         `PMS_IDX_STRETCH:   rd_mux = {20'h0_0000, stretch_tc_r};
         `PMS_IDX_DEBOUNCE:  rd_mux = {20'h0_0000, deb_tc_r};
         default:            rd_mux = `PMS_UNMAPPED_RD;
      endcase
   end

   // Read data captured in the setup cycle, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

endmodule

//--- pms_properties.sv
// Checker for the supervisor's pins, bound in from the bench top.
// Assumes one clock domain, with presetn as the lockout reset.
`timescale 1ns/100ps
`include "pms_regs.svh"
module pms_properties #(
   parameter int SLOW_DIV = 4
) (
   // Clock and lockout
   input wire logic              pclk,
   input wire logic              presetn,
   // Bus request
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   // Pins and monitor inputs
   input wire logic              buck2_enable,
   input wire logic              linreg_group_enable,
   input wire logic              over_temp,
   input wire pms_pkg::pms_cmp_s cmp,
   input wire logic              backup_rail_low,
   input wire logic              warm_reset_request_n,
   // Outputs watched
   input wire pms_pkg::pms_en_s  supply_on,
   input wire logic [7:0]        buck1_vsel,
   input wire logic              power_fail_flag,
   input wire logic              system_reset_out_o,
   input wire logic              system_reset_out_oe_n,
   input wire logic              irq_o,
   input wire logic              irq_oe_n
);
   import pms_pkg::*;
   logic [7:0] calm_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Cycles since any reset cause was last seen; saturates so it never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) calm_r <= 8'h00;
      else if (backup_rail_low || !warm_reset_request_n) calm_r <= 8'h00;
      else if (calm_r != 8'hFF) calm_r <= calm_r + 8'h01;
   end

   // Bus transfers the properties key on
   sequence rd_status;
      psel && penable && !pwrite && paddr == {`PMS_IDX_STATUS, 2'b00};
   endsequence
   sequence wr_buck1;
      psel && penable && pwrite && paddr == {`PMS_IDX_BUCK1_V, 2'b00};
   endsequence

   AST_NOEN_IRQ: assert property (supply_on == '0 |-> !irq_oe_n)
      else $error("interrupt released with no supply enabled");
   AST_PF_FLAG: assert property (cmp.trip[6] |=> power_fail_flag)
      else $error("power fail flag missed its trip");
   AST_HOT_OFF: assert property (over_temp [*2] |-> supply_on == '0)
      else $error("supply left on during over-temperature");
   AST_BACKUP_RST: assert property (backup_rail_low |=> !system_reset_out_oe_n)
      else $error("system reset released with backup rail low");
   AST_OPEN_DRAIN: assert property (!system_reset_out_o && !irq_o)
      else $error("open-drain pin driven high");
   AST_STRETCH: assert property ($rose(system_reset_out_oe_n) |-> calm_r >= 8'(2*SLOW_DIV))
      else $error("system reset released too early");
   AST_LINREG_PIN: assert property (!linreg_group_enable |=>
      !supply_on.linreg1 && !supply_on.linreg2)
      else $error("linear regulator on with group pin low");
   AST_BUCK2_PIN: assert property (!buck2_enable |=> !supply_on.buck2)
      else $error("buck2 on with its pin low");
   AST_WR_BUCK1: assert property (wr_buck1 ##0 (!backup_rail_low &&
      system_reset_out_oe_n) |=> {24'h00_0000, buck1_vsel} == ($past(pwdata) & 32'h0000_00FF))
      else $error("buck1 voltage write lost");
   AST_READ_QUIET: assert property (rd_status ##0 (!irq_oe_n && cmp.trip == '0) |=>
      irq_oe_n || supply_on == '0)
      else $error("status read did not release interrupt");
endmodule

//--- pms_host_pins.sv
// Board pull-ups and the host's view of the two open-drain pins.
// Assumes an output enable is low while the supervisor pulls its pin low.
`timescale 1ns/100ps
module pms_host_pins (
   // Open-drain drivers from the supervisor
   input  wire logic irq_o,
   input  wire logic irq_oe_n,
   input  wire logic system_reset_out_o,
   input  wire logic system_reset_out_oe_n,
   // Levels the host sees
   output wire logic irq_n_line,
   output wire logic rst_n_line
);
   // Released pins rise through the board pull-ups, never float
   assign irq_n_line = irq_oe_n ? 1'b1 : irq_o;
   assign rst_n_line = system_reset_out_oe_n ? 1'b1 : system_reset_out_o;
endmodule

//--- tb.sv
// Self-checking bench for the power supervisor over APB.
// Assumes the supervisor, its package and header, the checker and pin model.
`timescale 1ns/100ps
`include "pms_regs.svh"
module tb;
   import pms_pkg::*;
   localparam int SLOW_DIV = 4;
   // Clock, lockout and bus
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr;
   // Pins, straps and comparator results
   logic        buck1_enable = 1'b0, buck2_enable = 1'b0, buck3_enable = 1'b0;
   logic        linreg_group_enable = 1'b0, over_temp = 1'b0;
   logic        backup_rail_low = 1'b1, warm_reset_request_n = 1'b1;
   pms_strap_s  straps = '0;
   pms_cmp_s    cmp = '0;
   // Outputs and bookkeeping
   pms_en_s     supply_on;
   logic [7:0]  buck1_vsel, buck3_vsel;
   logic [15:0] linreg_voltage_control;
   logic        power_fail_flag, low_battery_flag, irq_n_line, rst_n_line;
   logic        system_reset_out_o, system_reset_out_oe_n, irq_o, irq_oe_n;
   int          n_mismatch = 0, check_count = 0, n;
   logic [15:0] lr [4] = '{{`PMS_V_3V3, `PMS_V_1V3}, {`PMS_V_3V3, `PMS_V_2V8},
                           {`PMS_V_1V8, `PMS_V_1V3}, {`PMS_V_3V3, `PMS_V_2V1}};

   pms_supervisor #(.SLOW_DIV(SLOW_DIV)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .buck1_enable, .buck2_enable,
      .buck3_enable, .linreg_group_enable, .over_temp, .straps, .cmp, .backup_rail_low,
      .warm_reset_request_n, .supply_on, .buck1_vsel, .buck3_vsel, .linreg_voltage_control,
      .power_fail_flag, .low_battery_flag, .system_reset_out_o, .system_reset_out_oe_n,
      .irq_o, .irq_oe_n);
   pms_host_pins u_pins (.irq_o, .irq_oe_n, .system_reset_out_o, .system_reset_out_oe_n,
      .irq_n_line, .rst_n_line);

   // 20 MHz bus clock
   always #25 pclk = ~pclk;

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge pclk);
   endtask

   // One transfer; request held until pready is seen, then an idle cycle
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      chk(pslverr, 1'b0);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // Pulse one comparator bit for a cycle; trip occupies the upper half
   task automatic pulse(input logic [13:0] v);
      cmp <= v;
      tick(1);
      cmp <= '0;
      tick(2);
   endtask

   // Bounded wait for the reset pin to be released, counting cycles
   task automatic wait_rel();
      n = 0;
      while (rst_n_line !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
   endtask

   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      // Each strap code across a lockout; backup rail held low meanwhile
      for (int k = 0; k < 4; k++) begin
         presetn <= 1'b0;
         straps <= {k[0], k[1], k[0], k[1]};
         tick(5);
         presetn <= 1'b1;
         tick(3);
         chk(buck1_vsel, k[0] ? `PMS_V_1V6 : `PMS_V_1V2);
         chk(buck3_vsel, k[1] ? `PMS_V_3V3 : `PMS_V_1V8);
         chk(linreg_voltage_control, lr[k]);
         straps <= ~straps;
         rd_chk(`PMS_IDX_MASK, 32'h0000_00C0);
         rd_chk(`PMS_IDX_SUPPLY_EN, 32'h0000_00FF);
         rd_chk(10'h3FF, `PMS_UNMAPPED_RD);
         chk(linreg_voltage_control, lr[k]);
         chk({irq_n_line, rst_n_line}, 2'b00);
      end
      apb(1'b1, `PMS_IDX_STRETCH, 32'h0000_0003);
      apb(1'b1, `PMS_IDX_DEBOUNCE, 32'h0000_0003);
      backup_rail_low <= 1'b0;
      wait_rel();
      chk(n >= 6 && n < 400, 1);
      // Enable pins, control register and forced shutdown
      {buck1_enable, buck2_enable, buck3_enable, linreg_group_enable} <= 4'hF;
      tick(3);
      chk({supply_on, irq_n_line}, 6'h3F);
      apb(1'b1, `PMS_IDX_SUPPLY_EN, 32'h0000_00EF);
      tick(1);
      chk(supply_on, 5'h17);
      buck2_enable <= 1'b0;
      tick(3);
      rd_chk(`PMS_IDX_SUPPLY_EN, 32'h0000_00FF);
      buck2_enable <= 1'b1;
      linreg_group_enable <= 1'b0;
      tick(3);
      chk(supply_on, 5'h1C);
      linreg_group_enable <= 1'b1;
      over_temp <= 1'b1;
      tick(3);
      chk(supply_on, 5'h00);
      over_temp <= 1'b0;
      apb(1'b1, `PMS_IDX_LINREG_V, 32'h0000_1234);
      chk({supply_on, linreg_voltage_control}, {5'h1F, 16'h1234});
      // Every source: set, read, quieten, recover
      for (int i = 0; i < 7; i++) begin
         pulse({7'h01 << i, 7'h00});
         chk(irq_n_line, i > 4);
         chk({power_fail_flag, low_battery_flag}, {i == 6, i == 5});
         rd_chk(`PMS_IDX_STATUS, 32'h0000_0001 << (i + 1));
         chk(irq_n_line, 1);
         rd_chk(`PMS_IDX_STATUS, 32'h0000_0001 << (i + 1));
         pulse({7'h00, 7'h01 << i});
         rd_chk(`PMS_IDX_STATUS, 32'h0000_0000);
      end
      // Masked source, then unmasked while still pending
      apb(1'b1, `PMS_IDX_MASK, 32'h0000_00E0);
      pulse({7'h10, 7'h00});
      chk(irq_n_line, 1);
      apb(1'b1, `PMS_IDX_MASK, 32'h0000_00C0);
      chk(irq_n_line, 0);
      pulse({7'h00, 7'h10});
      // Disabled rail ignores its comparator
      buck3_enable <= 1'b0;
      tick(3);
      pulse({7'h04, 7'h00});
      rd_chk(`PMS_IDX_STATUS, 32'h0000_0000);
      chk(irq_n_line, 1);
      {buck1_enable, buck2_enable, buck3_enable, linreg_group_enable} <= 4'h0;
      apb(1'b1, `PMS_IDX_MASK, 32'h0000_00FF);
      chk(irq_n_line, 0);
      apb(1'b1, `PMS_IDX_MASK, 32'h0000_00C0);
      // Warm reset: glitch filtered, held request resets buck1 only
      apb(1'b1, `PMS_IDX_BUCK1_V, 32'h0000_0050);
      warm_reset_request_n <= 1'b0;
      tick(2);
      warm_reset_request_n <= 1'b1;
      tick(20);
      chk({rst_n_line, buck1_vsel}, {1'b1, 8'h50});
      warm_reset_request_n <= 1'b0;
      tick(40);
      chk({rst_n_line, buck1_vsel}, {1'b0, `PMS_V_1V6});
      warm_reset_request_n <= 1'b1;
      wait_rel();
      rd_chk(`PMS_IDX_MASK, 32'h0000_00C0);
      chk(linreg_voltage_control, 16'h1234);
      // Backup rail low beats a buck1 write
      backup_rail_low <= 1'b1;
      tick(2);
      apb(1'b1, `PMS_IDX_BUCK1_V, 32'h0000_0055);
      chk({rst_n_line, buck1_vsel}, {1'b0, `PMS_V_1V6});
      backup_rail_low <= 1'b0;
      wait_rel();
      chk(n >= 6 && n < 400, 1);
      // Lockout in mid-run shuts everything down
      {buck1_enable, buck2_enable, buck3_enable, linreg_group_enable} <= 4'hF;
      tick(3);
      presetn <= 1'b0;
      tick(2);
      chk(supply_on, 5'h00);
      tally_and_finish();
   end
endmodule

bind pms_supervisor pms_properties #(.SLOW_DIV(SLOW_DIV)) u_props (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .buck2_enable, .linreg_group_enable, .over_temp,
   .cmp, .backup_rail_low, .warm_reset_request_n, .supply_on, .buck1_vsel,
   .power_fail_flag, .system_reset_out_o, .system_reset_out_oe_n, .irq_o, .irq_oe_n);
